//--- logic/apfs_pkg.sv
// Constants shared by the axis pin function selector
package apfs_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  ADDR_ENV      = 8'h00;
	localparam logic [7:0]  ADDR_PORT_OUT = 8'h04;
	localparam logic [7:0]  ADDR_PORT_IN  = 8'h08;
	localparam logic [31:0] ENV_RST       = 32'h0000_0000;
	localparam logic [31:0] ENV_MASK      = 32'h0001_ffff;
	localparam logic [7:0]  PORT_OUT_RST  = 8'h00;
	// ----------------------------------------
	// Field layout
	// ----------------------------------------
	localparam int          PINS          = 8;
	localparam int          FN_W          = 2;
	localparam int          POL_BIT       = 16;
	localparam int          SHOT_PINS     = 2;
	localparam logic [1:0]  FN_IN         = 2'h0;
	localparam logic [1:0]  FN_OUT        = 2'h1;
	localparam logic [1:0]  FN_STAT       = 2'h2;
	localparam logic [1:0]  FN_ALT        = 2'h3;
	// ----------------------------------------
	// Bus answers
	// ----------------------------------------
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int          CLK_HZ        = 100_000_000;
	localparam int          ONESHOT_MS    = 26;
	localparam int          ONESHOT_CYC   = ONESHOT_MS * (CLK_HZ / 1000);
endpackage

//--- logic/apfs_pin_select.sv
// Per-axis multipurpose pin function selector with AXI4-Lite registers
`timescale 1ns/1ps
// What this block does
// R1 - Pin0 code 10 drives acceleration status
// R2 - Pins 0,1 code 11 give 26 ms one-shot
// R3 - Code 00 input, code 01 output
// R4 - Pin1 field bits 2-3; 10 outputs deceleration
// R5 - Pin2 bits 4-5; constant speed low/high
// R6 - Pin3 compare1 match, 10 low, 11 high
// R7 - Pin4 compare2 match, 10 low, 11 high
// R8 - Pin5 compare3 match, 10 low, 11 high
// R9 - Pin6 bits 12-13; 10 compare4 low
// R10 - Pin7 compare5 match, 11 high, 10 low
// R11 - Pin0 polarity bit: 0 low, 1 high
// R12 - Fields in bits 0-15, polarity bit 16
// R13 - Output drives port level; input readable
module apfs_pin_select #(
	parameter int unsigned ONESHOT_CYCLES = apfs_pkg::ONESHOT_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic [2:0]  s_axi_awprot_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic [2:0]  s_axi_arprot_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        accelerating_status_i,
	input  wire logic        decelerating_status_i,
	input  wire logic        constant_speed_status_i,
	input  wire logic        compare1_match_i,
	input  wire logic        compare2_match_i,
	input  wire logic        compare3_match_i,
	input  wire logic        compare4_match_i,
	input  wire logic        compare5_match_i,
	input  wire logic [7:0]  pin_i,
	output logic [7:0]       pin_o,
	output logic [7:0]       pin_oe_n_o
);
	localparam int CW = $clog2(ONESHOT_CYCLES + 1);
	localparam logic [CW-1:0] SHOT_LOAD = CW'(ONESHOT_CYCLES);
	localparam logic [CW-1:0] CNT_ONE   = CW'(1);

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	logic [31:0]   env;
	logic [7:0]    port_out;
	logic [7:0]    pin_meta;
	logic [7:0]    pin_sync;
	logic          aw_held;
	logic          w_held;
	logic [7:0]    aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	logic [CW-1:0] shot_cnt [apfs_pkg::SHOT_PINS];

	// ----------------------------------------
	// Write channel decode
	// ----------------------------------------
	wire        aw_fire      = s_axi_awvalid_i & s_axi_awready_o;
	wire        w_fire       = s_axi_wvalid_i & s_axi_wready_o;
	wire        wr_go        = aw_held & w_held & ~s_axi_bvalid_o;
	wire        wr_env       = wr_go & (aw_addr == apfs_pkg::ADDR_ENV);
	wire        wr_port      = wr_go & (aw_addr == apfs_pkg::ADDR_PORT_OUT);
	wire        wr_hit       = wr_env | wr_port;
	wire        next_aw_held = (aw_held | aw_fire) & ~wr_go;
	wire        next_w_held  = (w_held | w_fire) & ~wr_go;
	wire        next_bvalid  = wr_go | (s_axi_bvalid_o & ~s_axi_bready_i);
	wire [31:0] byte_mask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	// Upper fields are not implemented here and read back as zero
	wire [31:0] next_env     = ((env & ~byte_mask) | (w_data & byte_mask)) & apfs_pkg::ENV_MASK; // [R12]
	wire [7:0]  next_port    = w_strb[0] ? w_data[7:0] : port_out;

	// ----------------------------------------
	// Read channel decode
	// ----------------------------------------
	wire        ar_fire      = s_axi_arvalid_i & s_axi_arready_o;
	wire        rd_env       = s_axi_araddr_i == apfs_pkg::ADDR_ENV;
	wire        rd_port      = s_axi_araddr_i == apfs_pkg::ADDR_PORT_OUT;
	wire        rd_in        = s_axi_araddr_i == apfs_pkg::ADDR_PORT_IN;
	wire        rd_hit       = rd_env | rd_port | rd_in;
	wire        next_rvalid  = ar_fire | (s_axi_rvalid_o & ~s_axi_rready_i);
	wire [31:0] rd_data      = rd_env  ? env :
	                           rd_port ? {24'h00_0000, port_out} :
	                           rd_in   ? {24'h00_0000, pin_sync} : 32'h0000_0000; // [R13]

	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			aw_held         <= 1'b0;
			w_held          <= 1'b0;
			aw_addr         <= 8'h00;
			w_data          <= 32'h0000_0000;
			w_strb          <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= apfs_pkg::RESP_OKAY;
		end else begin
			aw_held         <= next_aw_held;
			w_held          <= next_w_held;
			s_axi_awready_o <= ~next_aw_held;
			s_axi_wready_o  <= ~next_w_held;
			s_axi_bvalid_o  <= next_bvalid;
			if (aw_fire) begin
				aw_addr <= s_axi_awaddr_i;
			end
			if (w_fire) begin
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (wr_go) begin
				s_axi_bresp_o <= wr_hit ? apfs_pkg::RESP_OKAY : apfs_pkg::RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			env      <= apfs_pkg::ENV_RST;
			port_out <= apfs_pkg::PORT_OUT_RST;
		end else begin
			if (wr_env) begin
				env <= next_env; // [R12]
			end
			if (wr_port) begin
				port_out <= next_port; // [R13]
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= apfs_pkg::RESP_OKAY;
		end else begin
			s_axi_rvalid_o  <= next_rvalid;
			s_axi_arready_o <= ~next_rvalid;
			if (ar_fire) begin
				s_axi_rdata_o <= rd_data;
				s_axi_rresp_o <= rd_hit ? apfs_pkg::RESP_OKAY : apfs_pkg::RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------
	// Pin input synchroniser
	// ----------------------------------------
	// Pins come from outside; only the second stage is read
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end else begin
			pin_meta <= pin_i;
			pin_sync <= pin_meta; // [R13]
		end
	end

	// ----------------------------------------
	// One-shot timers for pins 0 and 1
	// ----------------------------------------
	// A port write with the bit set fires the pulse; a new trigger restarts it
	wire       pol_high = env[apfs_pkg::POL_BIT];
	wire [1:0] shot;
	wire [1:0] shot_trig;
	genvar s;
	generate
		for (s = 0; s < apfs_pkg::SHOT_PINS; s++) begin : g_shot
			assign shot_trig[s] = wr_port & w_strb[0] & w_data[s]
			                      & (env[s*apfs_pkg::FN_W +: apfs_pkg::FN_W] == apfs_pkg::FN_ALT);
			assign shot[s]      = shot_cnt[s] != '0;
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					shot_cnt[s] <= '0;
				end else if (shot_trig[s]) begin
					shot_cnt[s] <= SHOT_LOAD; // [R2]
				end else if (shot[s]) begin
					shot_cnt[s] <= shot_cnt[s] - CNT_ONE;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Function levels per code
	// ----------------------------------------
	// Code 10 level: pins 2..7 carry the status inverted
	wire [7:0] lvl_stat = {~compare5_match_i, ~compare4_match_i, ~compare3_match_i, // [R8] [R9] [R10]
	                       ~compare2_match_i, ~compare1_match_i,                    // [R6] [R7]
	                       ~constant_speed_status_i,                                // [R5]
	                       decelerating_status_i,                                   // [R4]
	                       accelerating_status_i ^ ~pol_high};                      // [R1] [R11]
	// Code 11 level: pins 2..7 carry the status as is
	wire [7:0] lvl_alt  = {compare5_match_i, compare4_match_i, compare3_match_i,    // [R8] [R10]
	                       compare2_match_i, compare1_match_i,                      // [R6] [R7]
	                       constant_speed_status_i,                                 // [R5]
	                       shot[1], shot[0] ^ ~pol_high};                           // [R2] [R11]

	// ----------------------------------------
	// Pin function multiplexer
	// ----------------------------------------
	wire [7:0] next_pin;
	wire [7:0] next_oe_n;
	genvar p;
	generate
		for (p = 0; p < apfs_pkg::PINS; p++) begin : g_pin
			wire [1:0] sel = env[p*apfs_pkg::FN_W +: apfs_pkg::FN_W]; // [R12]
			assign next_pin[p]  = (sel == apfs_pkg::FN_OUT)  ? port_out[p] : // [R3] [R13]
			                      (sel == apfs_pkg::FN_STAT) ? lvl_stat[p] :
			                      (sel == apfs_pkg::FN_ALT)  ? lvl_alt[p]  : 1'b0;
			assign next_oe_n[p] = sel == apfs_pkg::FN_IN; // [R3]
		end
	endgenerate

	// Registered so the pins never glitch while a field is rewritten
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_o      <= 8'h00;
			pin_oe_n_o <= 8'hff;
		end else begin
			pin_o      <= next_pin;
			pin_oe_n_o <= next_oe_n;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	wire [1:0] sel0 = env[1:0];
	wire [1:0] sel1 = env[3:2];
	wire [1:0] sel2 = env[5:4];
	wire [1:0] sel3 = env[7:6];
	wire [1:0] sel4 = env[9:8];
	wire [1:0] sel5 = env[11:10];
	wire [1:0] sel6 = env[13:12];
	wire [1:0] sel7 = env[15:14];

	AST_PIN0_ACCEL: assert property ((sel0 == apfs_pkg::FN_STAT) && pol_high |=> // [R1]
		pin_o[0] == $past(accelerating_status_i) && !pin_oe_n_o[0])
		else $error("pin0 does not follow acceleration status");
	AST_PIN0_POL_LOW: assert property ((sel0 == apfs_pkg::FN_STAT) && !pol_high |=> // [R11]
		pin_o[0] != $past(accelerating_status_i))
		else $error("pin0 polarity low not applied");
	AST_SHOT_LOAD: assert property (shot_trig[0] |=> shot_cnt[0] == SHOT_LOAD ##1 // [R2]
		shot_cnt[0] == SHOT_LOAD - CNT_ONE || $past(shot_trig[0]))
		else $error("one-shot timer not loaded with pulse width");
	AST_SHOT_PIN1: assert property ((sel1 == apfs_pkg::FN_ALT) && shot[1] |=> pin_o[1]) // [R2]
		else $error("pin1 one-shot pulse not on pin");
	AST_GP_INPUT: assert property ((sel3 == apfs_pkg::FN_IN) |=> pin_oe_n_o[3]) // [R3]
		else $error("input pin is being driven");
	AST_GP_OUTPUT: assert property ((sel5 == apfs_pkg::FN_OUT) |=> // [R3]
		!pin_oe_n_o[5] && pin_o[5] == $past(port_out[5]))
		else $error("output pin not driving port level");
	AST_PIN1_DECEL: assert property ((sel1 == apfs_pkg::FN_STAT) |=> pin_o[1] == $past(decelerating_status_i)) // [R4]
		else $error("pin1 does not follow deceleration status");
	AST_PIN2_CONST: assert property ((sel2 == apfs_pkg::FN_STAT) |=> // [R5]
		pin_o[2] == !$past(constant_speed_status_i))
		else $error("pin2 constant speed not inverted");
	AST_PIN3_CMP1: assert property ((sel3 == apfs_pkg::FN_ALT) |=> pin_o[3] == $past(compare1_match_i)) // [R6]
		else $error("pin3 compare1 positive wrong");
	AST_PIN4_CMP2: assert property ((sel4 == apfs_pkg::FN_STAT) |=> pin_o[4] == !$past(compare2_match_i)) // [R7]
		else $error("pin4 compare2 negative wrong");
	AST_PIN5_CMP3: assert property ((sel5 == apfs_pkg::FN_STAT) |=> pin_o[5] == !$past(compare3_match_i)) // [R8]
		else $error("pin5 compare3 negative wrong");
	AST_PIN6_CMP4: assert property ((sel6 == apfs_pkg::FN_STAT) |=> pin_o[6] == !$past(compare4_match_i)) // [R9]
		else $error("pin6 compare4 negative wrong");
	AST_PIN7_CMP5: assert property ((sel7 == apfs_pkg::FN_ALT) |=> pin_o[7] == $past(compare5_match_i)) // [R10]
		else $error("pin7 compare5 positive wrong");
	AST_ENV_WRITE: assert property (wr_env && (w_strb == 4'hf) |=> // [R12]
		env == ($past(w_data) & apfs_pkg::ENV_MASK) && s_axi_bvalid_o)
		else $error("environment register not updated");
	AST_PORT_IN_READ: assert property (ar_fire && rd_in |=> // [R13]
		s_axi_rvalid_o && s_axi_rdata_o == {24'h00_0000, $past(pin_sync)})
		else $error("pin levels not returned on read");

	// ----------------------------------------
	// One-shot, polarity and bus answer checks
	// ----------------------------------------
	// Pin0 polarity covers the pulse too, so an idle timer shows the inactive level
	AST_PIN0_SHOT_HIGH: assert property ((sel0 == apfs_pkg::FN_ALT) && pol_high |=> // [R11]
		pin_o[0] == $past(shot[0]))
		else $error("pin0 one-shot not active high");
	AST_PIN0_SHOT_LOW: assert property ((sel0 == apfs_pkg::FN_ALT) && !pol_high |=> // [R11]
		pin_o[0] != $past(shot[0]))
		else $error("pin0 one-shot not active low");
	AST_SHOT1_LOAD: assert property (shot_trig[1] |=> shot_cnt[1] == SHOT_LOAD) // [R2]
		else $error("pin1 one-shot timer not loaded with pulse width");
	AST_PIN1_SHOT_IDLE: assert property ((sel1 == apfs_pkg::FN_ALT) && !shot[1] |=> !pin_o[1]) // [R2]
		else $error("pin1 one-shot active without a pulse");
	AST_PIN2_DRIVEN: assert property ((sel2 != apfs_pkg::FN_IN) |=> !pin_oe_n_o[2]) // [R3]
		else $error("pin2 not driven although set as output");
	AST_PIN2_CONST_HIGH: assert property ((sel2 == apfs_pkg::FN_ALT) |=> // [R5]
		pin_o[2] == $past(constant_speed_status_i))
		else $error("pin2 constant speed positive wrong");
	AST_PIN3_CMP1_LOW: assert property ((sel3 == apfs_pkg::FN_STAT) |=> // [R6]
		pin_o[3] == !$past(compare1_match_i))
		else $error("pin3 compare1 negative wrong");
	AST_PIN4_CMP2_HIGH: assert property ((sel4 == apfs_pkg::FN_ALT) |=> // [R7]
		pin_o[4] == $past(compare2_match_i))
		else $error("pin4 compare2 positive wrong");
	AST_PIN5_CMP3_HIGH: assert property ((sel5 == apfs_pkg::FN_ALT) |=> // [R8]
		pin_o[5] == $past(compare3_match_i))
		else $error("pin5 compare3 positive wrong");
	AST_PIN7_CMP5_LOW: assert property ((sel7 == apfs_pkg::FN_STAT) |=> // [R10]
		pin_o[7] == !$past(compare5_match_i))
		else $error("pin7 compare5 negative wrong");
	AST_PORT_WRITE: assert property (wr_port && w_strb[0] |=> // [R13]
		port_out == $past(w_data[7:0]))
		else $error("port output register not updated");
	AST_BAD_WRITE_ERR: assert property (wr_go && !wr_hit |=> // [R13]
		s_axi_bvalid_o && s_axi_bresp_o == apfs_pkg::RESP_SLVERR && env == $past(env))
		else $error("unmapped write not refused");
	AST_BAD_READ_ERR: assert property (ar_fire && !rd_hit |=> // [R12]
		s_axi_rvalid_o && s_axi_rresp_o == apfs_pkg::RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000)
		else $error("unmapped read not refused");

	COV_WRITE: cover property (wr_env ##1 s_axi_bvalid_o && s_axi_bready_i);
	COV_READ: cover property (ar_fire && rd_in ##1 s_axi_rvalid_o && s_axi_rready_i);
	COV_SHOT: cover property (shot_trig[0] ##1 shot[0]);
	COV_SHOT1: cover property (shot_trig[1] ##1 shot[1]);
	COV_BADADDR: cover property (wr_go && !wr_hit);
endmodule

//--- verif/apfs_pin_partner.sv
// External equipment model wired to the eight multipurpose pins
`timescale 1ns/1ps
module apfs_pin_partner (
	input  wire logic [7:0] pin_o_i,
	input  wire logic [7:0] pin_oe_n_i,
	input  wire logic [7:0] drive_level_i,
	output logic [7:0]      pin_level_o
);
	// ----------------------------------------
	// Wire level
	// ----------------------------------------
	// A pin the block drives shows its level; a released pin shows what the equipment drives
	genvar g;
	for (g = 0; g < 8; g++) begin : g_pin
		assign pin_level_o[g] = pin_oe_n_i[g] ? drive_level_i[g] : pin_o_i[g];
	end
endmodule

//--- verif/apfs_pin_select_test.sv
// Self-checking bench for the axis pin function selector
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin errors++; \
	$display("FAIL %s expected %h seen %h", nm, exp, got); end end
module apfs_pin_select_test;
	logic        clk_i, sys_rst_i, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr, stat, ext_level;
	logic [31:0] wdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  rs;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [7:0]  pin_o, pin_oe_n, pin_level;
	int          errors, total_checks;
	localparam logic [7:0] PORT_PAT = 8'h96;
	// ----------------------------------------
	// Design and far side
	// ----------------------------------------
	apfs_pin_select #(.ONESHOT_CYCLES(8)) i_apfs_pin_select (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.accelerating_status_i(stat[0]), .decelerating_status_i(stat[1]), .constant_speed_status_i(stat[2]),
		.compare1_match_i(stat[3]), .compare2_match_i(stat[4]), .compare3_match_i(stat[5]),
		.compare4_match_i(stat[6]), .compare5_match_i(stat[7]), .pin_i(pin_level), .pin_o(pin_o),
		.pin_oe_n_o(pin_oe_n));
	apfs_pin_partner i_apfs_pin_partner (.pin_o_i(pin_o), .pin_oe_n_i(pin_oe_n), .drive_level_i(ext_level),
		.pin_level_o(pin_level));
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// Answers are sampled at the edge itself, before that edge's register updates land
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		bit aw_ok, w_ok;
		int n;
		aw_ok = 0;
		w_ok = 0;
		n = 0;
		r = 2'h3;
		@(posedge clk_i);
		awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (!(aw_ok && w_ok) && n < 200) begin
			@(posedge clk_i);
			n++;
			if (!aw_ok && awready === 1'b1) begin aw_ok = 1; awvalid <= 1'b0; end
			if (!w_ok && wready === 1'b1) begin w_ok = 1; wvalid <= 1'b0; end
		end
		while (n < 200) begin
			@(posedge clk_i);
			n++;
			if (bvalid === 1'b1) begin r = bresp; break; end
		end
		bready <= 1'b0;
		`CHK("write answer", 1'b1, n < 200)
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (n < 200) begin
			@(posedge clk_i);
			n++;
			if (arready === 1'b1) begin arvalid <= 1'b0; break; end
		end
		while (n < 200) begin
			@(posedge clk_i);
			n++;
			if (rvalid === 1'b1) begin d = rdata; r = rresp; break; end
		end
		rready <= 1'b0;
		`CHK("read answer", 1'b1, n < 200)
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_write(a, d, 4'hf, rs);
		`CHK("write resp", apfs_pkg::RESP_OKAY, rs)
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		axi_read(a, rd, rs);
		`CHK("read data", e, rd)
		`CHK("read resp", er, rs)
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		`CHK("oe_n after reset", 8'hff, pin_oe_n)
		`CHK("pin level after reset", 8'h00, pin_o)
		chk_reg(apfs_pkg::ADDR_ENV, 32'h0, apfs_pkg::RESP_OKAY);
		chk_reg(apfs_pkg::ADDR_PORT_OUT, 32'h0, apfs_pkg::RESP_OKAY);
		$display("test_reset done");
	endtask
	task automatic test_map();
		wr(apfs_pkg::ADDR_ENV, 32'hffff_ffff);
		chk_reg(apfs_pkg::ADDR_ENV, 32'h0001_ffff, apfs_pkg::RESP_OKAY);
		wr(apfs_pkg::ADDR_PORT_OUT, {24'h00_0000, PORT_PAT});
		chk_reg(apfs_pkg::ADDR_PORT_OUT, 32'h0000_0096, apfs_pkg::RESP_OKAY);
		chk_reg(8'h0c, 32'h0, apfs_pkg::RESP_SLVERR);
		axi_write(apfs_pkg::ADDR_PORT_IN, 32'hff, 4'hf, rs);
		`CHK("read-only write resp", apfs_pkg::RESP_SLVERR, rs)
		wr(apfs_pkg::ADDR_ENV, 32'h0);
		$display("test_map done");
	endtask
	// Every code on every pin, with two opposite status patterns and both pin0 polarities
	task automatic test_codes();
		logic [7:0] eo, eoe, s;
		logic e;
		for (int pol = 0; pol < 2; pol++) begin
			for (int p = 0; p < 8; p++) begin
				for (int c = 0; c < 4; c++) begin
					for (int k = 0; k < 2; k++) begin
						s = k ? 8'ha5 : 8'h5a;
						case (c)
							0: e = 1'b0;
							1: e = PORT_PAT[p];
							2: e = (p == 0) ? (pol ? s[0] : ~s[0]) : (p == 1) ? s[1] : ~s[p];
							default: e = (p == 0) ? ~pol[0] : (p == 1) ? 1'b0 : s[p];
						endcase
						eo = 8'h00;
						eoe = 8'hff;
						eo[p] = e;
						eoe[p] = (c == 0);
						@(posedge clk_i);
						stat <= s;
						wr(apfs_pkg::ADDR_ENV, (32'(pol) << 16) | (32'(c) << (2 * p)));
						repeat (3) @(posedge clk_i);
						`CHK("pin level", eo, pin_o)
						`CHK("pin enable", eoe, pin_oe_n)
					end
				end
			end
		end
		$display("test_codes done");
	endtask
	task automatic test_oneshot();
		int c0, c1;
		for (int pol = 0; pol < 2; pol++) begin
			c0 = 0;
			c1 = 0;
			wr(apfs_pkg::ADDR_ENV, (32'(pol) << 16) | 32'h0000_000f);
			repeat (12) @(posedge clk_i);
			fork
				repeat (40) begin
					@(posedge clk_i);
					if (pin_o[0] === pol[0]) c0++;
					if (pin_o[1] === 1'b1) c1++;
				end
				axi_write(apfs_pkg::ADDR_PORT_OUT, 32'h3, 4'h1, rs);
			join
			`CHK("pulse write resp", apfs_pkg::RESP_OKAY, rs)
			`CHK("pin0 pulse cycles", 8, c0)
			`CHK("pin1 pulse cycles", 8, c1)
			`CHK("pin0 idle", ~pol[0], pin_o[0])
		end
		$display("test_oneshot done");
	endtask
	task automatic test_port_in();
		wr(apfs_pkg::ADDR_ENV, 32'h0);
		@(posedge clk_i);
		ext_level <= 8'hc3;
		repeat (5) @(posedge clk_i);
		chk_reg(apfs_pkg::ADDR_PORT_IN, 32'h0000_00c3, apfs_pkg::RESP_OKAY);
		wr(apfs_pkg::ADDR_PORT_OUT, 32'h4);
		wr(apfs_pkg::ADDR_ENV, 32'h10);
		repeat (5) @(posedge clk_i);
		chk_reg(apfs_pkg::ADDR_PORT_IN, 32'h0000_00c7, apfs_pkg::RESP_OKAY);
		$display("test_port_in done");
	endtask
	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		errors = 0; total_checks = 0; sys_rst_i = 1'b1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
		rready = 0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0; stat = 8'h00; ext_level = 8'h00;
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		test_reset();
		test_map();
		test_codes();
		test_oneshot();
		test_port_in();
		complete_run();
	end
	// Whole run needs about 1200 cycles; over sixteen times that means a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		complete_run();
	end
endmodule
